/* File: logic/mscp_pkg.sv */
// Constants, state codes and opcodes of the monitor serial command port
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package mscp_pkg;
  localparam int SYS_CLK_HZ   = 25_000_000;  // Internal bus clock rate
  localparam int EXT_DIV      = 1024;        // External clocks per bit
  localparam int PLL_REF_HZ   = 32_768;      // Assumed crystal for ground entry
  localparam int PLL_BUS_HZ   = 2_457_600;   // Bus rate after PLL
  localparam int PLL_MULT     = PLL_BUS_HZ / PLL_REF_HZ;
  localparam int BUS_PER_BIT  = EXT_DIV / 4; // Bus is external clock over four
  localparam int PLL_BAUD     = PLL_BUS_HZ / BUS_PER_BIT;
  localparam int LEN_W        = 20;          // Width of bit length counters
  localparam logic [LEN_W-1:0] PLL_BIT_CYC = LEN_W'(SYS_CLK_HZ / PLL_BAUD);
  localparam logic [10:0] EXT_DIV_EDGES   = 11'(EXT_DIV);
  localparam logic [3:0]  FRAME_BITS      = 4'ha;  // Start, 8 data, stop
  localparam logic [3:0]  STOP_IDX        = 4'h9;
  localparam logic [3:0]  GAP_BITS        = 4'h2;
  localparam logic [3:0]  CANCEL_BITS     = 4'hb;
  localparam logic [3:0]  SEC_BYTES       = 4'h8;
  localparam logic [1:0]  ENTRY_SETTLE    = 2'h3;  // Cycles for pin synchronisers
  localparam logic [15:0] IDX_RST         = 16'h0000;
  localparam logic [7:0]  OP_MEM_READ     = 8'h4a;
  localparam logic [7:0]  OP_MEM_WRITE    = 8'h49;
  localparam int          TX_W            = 9;     // Break flag and byte
  localparam int          TX_DEPTH        = 16;
  typedef enum logic [10:0] {
    S_ENTRY = 11'h001, S_CAL   = 11'h002, S_OFF   = 11'h004, S_SEC   = 11'h008,
    S_IDLE  = 11'h010, S_ARG   = 11'h020, S_WAIT  = 11'h040, S_EXEC  = 11'h080,
    S_RDREQ = 11'h100, S_RDATA = 11'h200, S_PUSH  = 11'h400
  } mscp_eng_t;
  typedef enum logic [2:0] {R_IDLE = 3'h1, R_BITS = 3'h2, R_HOLD = 3'h4} mscp_rx_t;
  typedef enum logic [2:0] {T_IDLE = 3'h1, T_GAP = 3'h2, T_SHIFT = 3'h4} mscp_tx_t;
endpackage

/* File: logic/mscp_port.sv */
// Monitor serial command port: transmit queue and command interpreter
`timescale 1ns/1ps

//------------------------------------------------------------------------------
// Transmit queue
//------------------------------------------------------------------------------
module mscp_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 16
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_reg;
  logic [AW:0]  wr_next;
  logic [AW:0]  rd_reg;
  logic [AW:0]  rd_next;
  logic         push;

  // Full and empty from pointers with wrap bit
  assign in_ready  = !((wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]));
  assign out_valid = (wr_reg != rd_reg);
  assign out_data  = mem[rd_reg[AW-1:0]];
  assign push      = in_valid && in_ready;

  // Pointer advance
  always_comb
  begin
    wr_next = push ? wr_reg + 1'b1 : wr_reg;
    rd_next = (out_valid && out_ready) ? rd_reg + 1'b1 : rd_reg;
  end

  // Pointer and storage registers
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
    end
    else
    begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
    end
    if (push)
      mem[wr_reg[AW-1:0]] <= in_data;
  end
endmodule

//------------------------------------------------------------------------------
// Command port
//------------------------------------------------------------------------------
module mscp_port #(
  parameter logic [7:0] OP_INDEXED_READ  = 8'h1a,  // Opcode value arbitrary
  parameter logic [7:0] OP_INDEXED_WRITE = 8'h19,  // Opcode value arbitrary
  parameter logic [7:0] OP_SP_READ       = 8'h0c,  // Opcode value arbitrary
  parameter logic [7:0] OP_RUN           = 8'h28,  // Opcode value arbitrary
  parameter int         BIT_DIV          = mscp_pkg::EXT_DIV  // External clocks per bit
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        monitor_serial_pin_in,
  output logic             monitor_serial_pin_out,
  output logic             monitor_serial_pin_oe,
  input  wire logic        ext_clk,
  input  wire logic        irq_test_high_voltage,
  input  wire logic        irq_grounded,
  input  wire logic        reset_vector_blank,
  input  wire logic [15:0] stack_pointer,
  output logic [15:0]      mem_addr,
  output logic [7:0]       mem_wdata,
  output logic             mem_we,
  output logic             mem_re,
  input  wire logic [7:0]  mem_rdata,
  output logic             run_user,
  output logic             cmd_cancelled,
  output logic             monitor_active,
  output logic             pll_enable
);
  import mscp_pkg::*;

  // Decode opcode: known flag and operand count
  function automatic logic [2:0] cmd_args(input logic [7:0] op);
    cmd_args = 3'h0;
    if (op == OP_MEM_READ)           cmd_args = 3'h6;
    else if (op == OP_MEM_WRITE)     cmd_args = 3'h7;
    else if (op == OP_INDEXED_WRITE) cmd_args = 3'h5;
    else if ((op == OP_INDEXED_READ) || (op == OP_SP_READ) || (op == OP_RUN))
      cmd_args = 3'h4;
  endfunction

  logic rx_s1, rx_s2, rx_prev, ext_s1, ext_s2, ext_prev, hv_s1, hv_s2, gnd_s1, gnd_s2;
  logic             fifo_in_ready, fifo_out_valid, tx_pop;
  logic [TX_W-1:0]  fifo_out_data;
  logic             tx_busy, ext_rise;
  logic [2:0]       op_args;
  // Engine state
  mscp_eng_t        e_reg, e_next;
  logic [1:0]       settle_reg, settle_next;
  logic [10:0]      edges_reg, edges_next;
  logic [LEN_W-1:0] tick_reg, tick_next, bit_len_reg, bit_len_next;
  logic [3:0]       cnt_reg, cnt_next;
  logic [7:0]       op_reg, op_next, data_reg, data_next;
  logic [15:0]      addr_reg, addr_next, idx_reg, idx_next;
  logic [1:0]       left_reg, left_next;
  logic             brk_reg, brk_next, push_req_reg, push_req_next;
  logic [TX_W-1:0]  push_dat_reg, push_dat_next;
  logic [15:0]      mem_addr_next;
  logic [7:0]       mem_wdata_next;
  logic             mem_we_next, mem_re_next, run_next, cancel_next, active_next, pll_next;
  // Receiver state
  mscp_rx_t         r_reg, r_next;
  logic [LEN_W-1:0] r_tick_reg, r_tick_next;
  logic [3:0]       r_bits_reg, r_bits_next;
  logic [7:0]       r_sh_reg, r_sh_next;
  logic             rx_valid_reg, rx_valid_next, rx_break_reg, rx_break_next;
  // Transmitter state
  mscp_tx_t         t_reg, t_next;
  logic [LEN_W-1:0] t_tick_reg, t_tick_next;
  logic [3:0]       t_bits_reg, t_bits_next;
  logic [9:0]       t_frame_reg, t_frame_next;
  logic             out_next, oe_next;

  // Pin synchronisers
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      {rx_s1, rx_s2, rx_prev, ext_s1, ext_s2, ext_prev, hv_s1, hv_s2, gnd_s1, gnd_s2} <= 10'h3f8;
    else
    begin
      {rx_s1, rx_s2, rx_prev} <= {monitor_serial_pin_in, rx_s1, rx_s2};
      {ext_s1, ext_s2, ext_prev} <= {ext_clk, ext_s1, ext_s2};
      {hv_s1, hv_s2, gnd_s1, gnd_s2} <= {irq_test_high_voltage, hv_s1, irq_grounded, gnd_s1};
    end
  end
  assign ext_rise = ext_s2 && !ext_prev;
  assign tx_busy  = (t_reg != T_IDLE);
  assign op_args  = cmd_args(r_sh_reg);  // Known flag and operand count of last byte

  // Queue of echoes and responses toward the transmitter
  mscp_fifo #(.W(TX_W), .DEPTH(TX_DEPTH)) u_txq (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .in_valid  (push_req_reg),
    .in_ready  (fifo_in_ready),
    .in_data   (push_dat_reg),
    .out_valid (fifo_out_valid),
    .out_ready (tx_pop),
    .out_data  (fifo_out_data)
  );

  //----------------------------------------------------------------------------
  // Receiver
  //----------------------------------------------------------------------------
  // Mid-bit sampling of start, data and stop
  always_comb
  begin
    r_next = r_reg;
    r_tick_next = r_tick_reg;
    r_bits_next = r_bits_reg;
    r_sh_next = r_sh_reg;
    rx_valid_next = 1'b0;
    rx_break_next = 1'b0;
    unique case (r_reg)
      R_IDLE:
        if (monitor_active && !tx_busy && rx_prev && !rx_s2)
        begin
          r_next = R_BITS;
          r_tick_next = bit_len_reg >> 1;
          r_bits_next = 4'h0;
        end
      R_BITS:
        if (r_tick_reg == '0)
        begin
          r_tick_next = bit_len_reg - 1'b1;
          r_bits_next = r_bits_reg + 1'b1;
          if (r_bits_reg == 4'h0)
          begin
            if (rx_s2)
              r_next = R_IDLE;                       // Glitch, not a start bit
          end
          else if (r_bits_reg != STOP_IDX)
            r_sh_next = {rx_s2, r_sh_reg[7:1]};
          else if (rx_s2)
          begin
            rx_valid_next = 1'b1;
            r_next = R_IDLE;
          end
          else
          begin
            rx_break_next = (r_sh_reg == 8'h00);
            r_next = R_HOLD;
          end
        end
        else
          r_tick_next = r_tick_reg - 1'b1;
      R_HOLD:
        if (rx_s2)
          r_next = R_IDLE;
      default:
        r_next = R_IDLE;
    endcase
  end

  // Receiver registers
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      r_reg <= R_IDLE;
      r_tick_reg <= '0;
      r_bits_reg <= 4'h0;
      r_sh_reg <= 8'h00;
      rx_valid_reg <= 1'b0;
      rx_break_reg <= 1'b0;
    end
    else
    begin
      r_reg <= r_next;
      r_tick_reg <= r_tick_next;
      r_bits_reg <= r_bits_next;
      r_sh_reg <= r_sh_next;
      rx_valid_reg <= rx_valid_next;
      rx_break_reg <= rx_break_next;
    end
  end

  //----------------------------------------------------------------------------
  // Transmitter
  //----------------------------------------------------------------------------
  assign tx_pop = (t_reg == T_IDLE) && monitor_active;

  // Two high bits of gap, then a frame or a break
  always_comb
  begin
    t_next = t_reg;
    t_tick_next = t_tick_reg;
    t_bits_next = t_bits_reg;
    t_frame_next = t_frame_reg;
    out_next = monitor_serial_pin_out;
    oe_next = monitor_serial_pin_oe;
    unique case (t_reg)
      T_IDLE:
        if (tx_pop && fifo_out_valid)
        begin
          t_next = T_GAP;
          t_tick_next = '0;
          t_bits_next = GAP_BITS;
          t_frame_next = fifo_out_data[8] ? 10'h000 : {1'b1, fifo_out_data[7:0], 1'b0};
          out_next = 1'b1;
          oe_next = 1'b1;
        end
      T_GAP, T_SHIFT:
        if (t_tick_reg == bit_len_reg - 1'b1)
        begin
          t_tick_next = '0;
          t_bits_next = t_bits_reg - 1'b1;
          if (t_reg == T_GAP && t_bits_reg == 4'h1)
          begin
            t_next = T_SHIFT;
            t_bits_next = FRAME_BITS;
            out_next = t_frame_reg[0];
          end
          else if (t_reg == T_SHIFT)
          begin
            t_frame_next = t_frame_reg >> 1;
            out_next = t_frame_reg[1];
            if (t_bits_reg == 4'h1)
            begin
              t_next = T_IDLE;
              out_next = 1'b1;
              oe_next = 1'b0;
            end
          end
        end
        else
          t_tick_next = t_tick_reg + 1'b1;
      default:
        t_next = T_IDLE;
    endcase
  end

  // Transmitter registers
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      t_reg <= T_IDLE;
      t_tick_reg <= '0;
      t_bits_reg <= 4'h0;
      t_frame_reg <= 10'h3ff;
      monitor_serial_pin_out <= 1'b1;
      monitor_serial_pin_oe <= 1'b0;
    end
    else
    begin
      t_reg <= t_next;
      t_tick_reg <= t_tick_next;
      t_bits_reg <= t_bits_next;
      t_frame_reg <= t_frame_next;
      monitor_serial_pin_out <= out_next;
      monitor_serial_pin_oe <= oe_next;
    end
  end

  //----------------------------------------------------------------------------
  // Command engine
  //----------------------------------------------------------------------------
  // Entry, calibration, echo, cancel window and execution
  always_comb
  begin
    e_next = e_reg;
    settle_next = settle_reg;
    edges_next = edges_reg;
    tick_next = tick_reg;
    bit_len_next = bit_len_reg;
    cnt_next = cnt_reg;
    op_next = op_reg;
    data_next = data_reg;
    addr_next = addr_reg;
    idx_next = idx_reg;
    left_next = left_reg;
    brk_next = brk_reg;
    push_req_next = push_req_reg && !fifo_in_ready;
    push_dat_next = push_dat_reg;
    mem_addr_next = mem_addr;
    mem_wdata_next = mem_wdata;
    mem_we_next = 1'b0;
    mem_re_next = 1'b0;
    run_next = 1'b0;
    cancel_next = 1'b0;
    active_next = monitor_active;
    pll_next = pll_enable;
    // Echo of bytes and breaks while listening
    if ((e_reg == S_SEC || e_reg == S_IDLE || e_reg == S_ARG || e_reg == S_WAIT) && !push_req_next)
    begin
      if (rx_valid_reg)
      begin
        push_req_next = 1'b1;
        push_dat_next = {1'b0, r_sh_reg};
      end
      else if (rx_break_reg)
      begin
        push_req_next = 1'b1;
        push_dat_next = {1'b1, 8'h00};
      end
    end
    unique case (e_reg)
      S_ENTRY:
        if (settle_reg == ENTRY_SETTLE)
        begin
          if (!hv_s2 && !reset_vector_blank)
            e_next = S_OFF;
          else if (!hv_s2 && gnd_s2)
          begin
            pll_next = 1'b1;
            bit_len_next = PLL_BIT_CYC;
            active_next = 1'b1;
            e_next = S_SEC;
          end
          else
            e_next = S_CAL;
          cnt_next = 4'h0;
          edges_next = '0;
        end
        else
          settle_next = settle_reg + 1'b1;
      S_CAL:
      begin
        tick_next = tick_reg + 1'b1;
        if (ext_rise)
        begin
          edges_next = edges_reg + 1'b1;
          if (edges_reg == '0)
            tick_next = LEN_W'(1);
          else if (edges_reg == 11'(BIT_DIV))
          begin
            bit_len_next = tick_reg;
            active_next = 1'b1;
            e_next = S_SEC;
          end
        end
      end
      S_SEC:
        if (rx_valid_reg)
        begin
          cnt_next = cnt_reg + 1'b1;
          if (cnt_reg == SEC_BYTES - 1'b1)
          begin
            brk_next = 1'b1;
            left_next = 2'h1;
            e_next = S_PUSH;
          end
        end
      S_IDLE:
        if (rx_valid_reg && op_args[2])
        begin
          op_next = r_sh_reg;
          cnt_next = {2'b00, op_args[1:0]};
          tick_next = '0;
          if (op_args[1:0] == 2'h0)
          begin
            cnt_next = CANCEL_BITS;
            e_next = S_WAIT;
          end
          else
            e_next = S_ARG;
        end
      S_ARG:
        if (rx_break_reg)
        begin
          cancel_next = 1'b1;
          e_next = S_IDLE;
        end
        else if (rx_valid_reg)
        begin
          addr_next = {addr_reg[7:0], data_reg};
          data_next = r_sh_reg;
          cnt_next = cnt_reg - 1'b1;
          if (cnt_reg == 4'h1)
          begin
            cnt_next = CANCEL_BITS;
            tick_next = '0;
            e_next = S_WAIT;
          end
        end
      S_WAIT:
        if (rx_break_reg)
        begin
          cancel_next = 1'b1;
          e_next = S_IDLE;
        end
        else if (tx_busy || fifo_out_valid || push_req_reg || rx_valid_reg)
          tick_next = '0;
        else if (tick_reg == bit_len_reg - 1'b1)
        begin
          tick_next = '0;
          cnt_next = cnt_reg - 1'b1;
          if (cnt_reg == 4'h1)
            e_next = S_EXEC;
        end
        else
          tick_next = tick_reg + 1'b1;
      S_EXEC:
      begin
        brk_next = 1'b0;
        e_next = S_IDLE;
        if (op_reg == OP_MEM_READ)
        begin
          addr_next = {addr_reg[7:0], data_reg};
          left_next = 2'h1;
          e_next = S_RDREQ;
        end
        else if (op_reg == OP_INDEXED_READ)
        begin
          addr_next = idx_reg;
          left_next = 2'h2;
          e_next = S_RDREQ;
        end
        else if (op_reg == OP_SP_READ)
        begin
          data_next = stack_pointer[15:8];
          left_next = 2'h2;
          e_next = S_PUSH;
        end
        else if (op_reg == OP_MEM_WRITE || op_reg == OP_INDEXED_WRITE)
        begin
          mem_addr_next = (op_reg == OP_MEM_WRITE) ? addr_reg : idx_reg;
          mem_wdata_next = data_reg;
          mem_we_next = 1'b1;
          idx_next = mem_addr_next + 1'b1;
        end
        else
          run_next = 1'b1;
      end
      S_RDREQ:
      begin
        mem_addr_next = addr_reg;
        mem_re_next = 1'b1;
        e_next = S_RDATA;
      end
      S_RDATA:
      begin
        data_next = mem_rdata;
        addr_next = addr_reg + 1'b1;
        idx_next = addr_reg + 1'b1;
        e_next = S_PUSH;
      end
      S_PUSH:
        if (!push_req_reg)
        begin
          push_req_next = 1'b1;
          push_dat_next = {brk_reg, data_reg};
          left_next = left_reg - 1'b1;
          if (left_reg == 2'h1)
          begin
            brk_next = 1'b0;
            e_next = S_IDLE;
          end
          else if (op_reg == OP_SP_READ)
            data_next = stack_pointer[7:0];
          else
            e_next = S_RDREQ;
        end
      S_OFF:
        active_next = 1'b0;
      default:
        e_next = S_ENTRY;
    endcase
  end

  // Engine registers
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      e_reg <= S_ENTRY;
      {settle_reg, edges_reg, tick_reg, bit_len_reg, cnt_reg} <= '0;
      {op_reg, data_reg, addr_reg, left_reg, brk_reg, push_req_reg, push_dat_reg} <= '0;
      idx_reg <= IDX_RST;
      {mem_addr, mem_wdata, mem_we, mem_re, run_user, cmd_cancelled} <= '0;
      {monitor_active, pll_enable} <= 2'b00;
    end
    else
    begin
      e_reg <= e_next;
      {settle_reg, edges_reg, tick_reg, bit_len_reg, cnt_reg} <=
        {settle_next, edges_next, tick_next, bit_len_next, cnt_next};
      {op_reg, data_reg, addr_reg, left_reg, brk_reg, push_req_reg, push_dat_reg} <=
        {op_next, data_next, addr_next, left_next, brk_next, push_req_next, push_dat_next};
      idx_reg <= idx_next;
      {mem_addr, mem_wdata, mem_we, mem_re, run_user, cmd_cancelled} <=
        {mem_addr_next, mem_wdata_next, mem_we_next, mem_re_next, run_next, cancel_next};
      {monitor_active, pll_enable} <= {active_next, pll_next};
    end
  end
endmodule

/* File: test/mscp_port_sva.sv */
// Assertions on the monitor serial command port outputs
`timescale 1ns/1ps
module mscp_port_sva (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic monitor_serial_pin_out,
  input wire logic monitor_serial_pin_oe,
  input wire logic mem_we,
  input wire logic mem_re,
  input wire logic run_user,
  input wire logic cmd_cancelled,
  input wire logic monitor_active
);
  localparam logic [19:0] WIN = 20'(11 * 38);  // Eleven 40-cycle bits less slack
  logic [19:0] idle_reg;
  logic [19:0] idle_next;
  // Cycles since the device let go of the line
  always_comb
  begin
    idle_next = (monitor_serial_pin_oe || !rstn) ? 20'h00000 : idle_reg + 20'h00001;
  end
  always_ff @(posedge sys_clk)
  begin
    idle_reg <= idle_next;
  end
  //----------------------------------------------------------------------------
  // Properties
  //----------------------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  rst_idle_a: assert property ($rose(rstn) |-> monitor_serial_pin_out && !monitor_serial_pin_oe)
    else $error("line not idle after reset");
  gap_high_a: assert property ($rose(monitor_serial_pin_oe) |-> monitor_serial_pin_out [*8])
    else $error("gap not high");
  we_pulse_a: assert property (mem_we |=> !mem_we)
    else $error("write strobe too long");
  re_pulse_a: assert property (mem_re |=> !mem_re)
    else $error("read strobe too long");
  cmd_window_a: assert property (mem_we |-> idle_reg >= WIN)
    else $error("write before the wait window ended");
  cancel_drop_a: assert property (cmd_cancelled |=> (!mem_we && !cmd_cancelled) [*8])
    else $error("write after cancel");
  run_pulse_a: assert property (run_user |=> !run_user)
    else $error("run strobe too long");
  entry_gate_a: assert property ((monitor_serial_pin_oe || mem_we || mem_re || run_user) |-> monitor_active)
    else $error("activity while monitor off");
endmodule

bind mscp_port mscp_port_sva chk (.sys_clk, .rstn, .monitor_serial_pin_out, .monitor_serial_pin_oe,
  .mem_we, .mem_re, .run_user, .cmd_cancelled, .monitor_active);

/* File: test/mscp_host.sv */
// Host model driving and receiving the monitor serial line
`timescale 1ns/1ps
module mscp_host #(
  parameter int BIT = 40
) (
  input wire logic sys_clk,
  input wire logic line,
  output logic     host_oe,
  output logic     host_val
);
  initial
  begin
    host_oe = 1'b0;
    host_val = 1'b1;
  end
  // One idle bit, then a frame or ten low bits, then let go
  task automatic send(input logic [7:0] b, input logic brk);
    logic [9:0] fr;
    fr = brk ? 10'h000 : {1'b1, b, 1'b0};
    repeat (BIT) @(posedge sys_clk);
    for (int i = 0; i < 10; i++)
    begin
      host_oe <= 1'b1;
      host_val <= fr[i];
      repeat (BIT) @(posedge sys_clk);
    end
    host_oe <= 1'b0;
  endtask
  // Bounded start search, then mid-bit samples of data and stop
  task automatic recv(output logic [8:0] r, output logic ok);
    int n;
    n = 0;
    r = 9'h000;
    while (line !== 1'b0 && n < 40 * BIT)
    begin
      @(posedge sys_clk);
      n++;
    end
    ok = (line === 1'b0);
    repeat (BIT / 2) @(posedge sys_clk);
    for (int i = 0; i < 9; i++)
    begin
      repeat (BIT) @(posedge sys_clk);
      r[i] = line;
    end
  endtask
endmodule

/* File: test/tb.sv */
// Self-checking bench for the monitor serial command port
`timescale 1ns/1ps
module tb;
  import mscp_pkg::*;
  logic        sys_clk, rstn, ext_clk, irq_test_high_voltage, irq_grounded, reset_vector_blank;
  logic        monitor_serial_pin_in, monitor_serial_pin_out, monitor_serial_pin_oe, host_oe, host_val;
  logic        mem_we, mem_re, run_user, cmd_cancelled, monitor_active, pll_enable;
  logic [15:0] stack_pointer, mem_addr;
  logic [7:0]  mem_wdata, mem_rdata;
  logic [7:0]  mem [0:65535];
  int          error_cnt = 0, n_checks = 0, we_cnt = 0, cancel_cnt = 0, run_cnt = 0;
  // Wire with pull-up; the device wins while it drives
  assign monitor_serial_pin_in = monitor_serial_pin_oe ? monitor_serial_pin_out : (host_oe ? host_val : 1'b1);
  assign mem_rdata = mem[mem_addr];
  // Short divider keeps bits at 40 cycles so the run stays brief
  mscp_port #(.BIT_DIV(16)) dut (.sys_clk, .rstn, .monitor_serial_pin_in, .monitor_serial_pin_out,
    .monitor_serial_pin_oe, .ext_clk, .irq_test_high_voltage, .irq_grounded, .reset_vector_blank, .stack_pointer,
    .mem_addr, .mem_wdata, .mem_we, .mem_re, .mem_rdata, .run_user, .cmd_cancelled, .monitor_active, .pll_enable);
  mscp_host host (.sys_clk, .line(monitor_serial_pin_in), .host_oe, .host_val);
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // External clock at 10 MHz; a divider of 16 gives 40-cycle bits
  initial
  begin
    ext_clk = 1'b0;
    #7;
    forever #50 ext_clk = ~ext_clk;
  end
  // Memory behind the port and pulse counters
  always @(posedge sys_clk)
  begin
    if (mem_we)
      mem[mem_addr] <= mem_wdata;
    we_cnt <= we_cnt + int'(mem_we);
    cancel_cnt <= cancel_cnt + int'(cmd_cancelled);
    run_cnt <= run_cnt + int'(run_user);
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Receive one item from the device and compare stop and data
  task automatic rx(input logic [8:0] exp);
    logic [8:0] r;
    logic       ok;
    host.recv(r, ok);
    chk({6'h00, ok, r}, {6'h00, 1'b1, exp});
    if (ok !== 1'b1)
      report_and_stop();
  endtask
  // Send one item and expect it back
  task automatic tx(input logic [7:0] b, input logic brk);
    host.send(b, brk);
    rx(brk ? 9'h000 : {1'b1, b});
  endtask
  // Bounded wait until a pulse counter reaches a value
  task automatic wait_cnt(ref int cnt, input int goal);
    int n;
    n = 0;
    while (cnt < goal && n < 20 * 40)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk(16'(cnt), 16'(goal));
    if (cnt < goal)
      report_and_stop();
  endtask
  task automatic reset_dut(input logic tv);
    @(posedge sys_clk);
    rstn <= 1'b0;
    irq_test_high_voltage <= tv;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
  endtask
  // Supply-level entry without a blank vector stays silent
  task automatic t_refused();
    reset_dut(1'b0);
    repeat (6000) @(posedge sys_clk);
    chk({14'h0, monitor_active, monitor_serial_pin_oe}, 16'h0000);
  endtask
  // Ground entry with a blank vector starts on the PLL at once
  task automatic t_ground();
    irq_grounded <= 1'b1;
    reset_vector_blank <= 1'b1;
    reset_dut(1'b0);
    repeat (20) @(posedge sys_clk);
    chk({14'h0, monitor_active, pll_enable}, 16'h0003);
  endtask
  // Test-voltage entry calibrates from the external clock
  task automatic t_entry();
    int n;
    n = 0;
    reset_dut(1'b1);
    while (monitor_active !== 1'b1 && n < 8000)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk({14'h0, monitor_active, pll_enable}, 16'h0002);
    if (monitor_active !== 1'b1)
      report_and_stop();
  endtask
  // Security bytes, ready break, then a break from the host
  task automatic t_security();
    for (int i = 0; i < 8; i++)
      tx(8'(i * 37 + 1), 1'b0);
    rx(9'h000);
    tx(8'h00, 1'b1);
  endtask
  // Write one byte, then read it back
  task automatic t_write_read();
    tx(OP_MEM_WRITE, 1'b0);
    tx(8'h12, 1'b0);
    tx(8'h34, 1'b0);
    tx(8'ha5, 1'b0);
    wait_cnt(we_cnt, 1);
    chk(mem_addr, 16'h1234);
    chk({8'h00, mem_wdata}, 16'h00a5);
    tx(OP_MEM_READ, 1'b0);
    tx(8'h12, 1'b0);
    tx(8'h34, 1'b0);
    rx({1'b1, 8'ha5});
  endtask
  // Indexed write at the index, then indexed read of the next two
  task automatic t_indexed();
    tx(dut.OP_INDEXED_WRITE, 1'b0);
    tx(8'h77, 1'b0);
    wait_cnt(we_cnt, 2);
    chk(mem_addr, 16'h1235);
    chk({8'h00, mem_wdata}, 16'h0077);
    tx(dut.OP_INDEXED_READ, 1'b0);
    rx({1'b1, 8'h3e});
    rx({1'b1, 8'h4f});
  endtask
  // Stack pointer read, then run
  task automatic t_sp_run();
    tx(dut.OP_SP_READ, 1'b0);
    rx({1'b1, 8'hc3});
    rx({1'b1, 8'h5a});
    tx(dut.OP_RUN, 1'b0);
    wait_cnt(run_cnt, 1);
  endtask
  // Break inside the wait window drops a write
  task automatic t_cancel();
    tx(OP_MEM_WRITE, 1'b0);
    tx(8'h12, 1'b0);
    tx(8'h40, 1'b0);
    tx(8'h3c, 1'b0);
    tx(8'h00, 1'b1);
    wait_cnt(cancel_cnt, 1);
    chk(16'(we_cnt), 16'h0002);
  endtask
  initial
  begin
    rstn = 1'b0;
    irq_test_high_voltage = 1'b0;
    irq_grounded = 1'b0;
    reset_vector_blank = 1'b0;
    stack_pointer = 16'hc35a;
    mem[16'h1236] = 8'h3e;
    mem[16'h1237] = 8'h4f;
    t_refused();
    t_ground();
    t_entry();
    t_security();
    t_write_read();
    t_indexed();
    t_sp_run();
    t_cancel();
    report_and_stop();
  end
endmodule
